// file: homing_interrupt_positioner.sv
// Homing methods 6 to 9 and interrupt positioning behind an AXI4-Lite slave
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - Method 6 low start: out, back, slow, stop
// R2 - Method 6 high start: back fast, slow forward
// R3 - Method 7 low start: mirror of method 6
// R4 - Method 7 high start: forward fast, slow reverse
// R5 - Method 8 low start: slow reverse, stop index
// R6 - Method 8 high start: reverse, stop on index
// R7 - Method 9 low start: slow forward, stop index
// R8 - Method 9 high start: forward, stop index
// R9 - Trigger aborts motion, shields external reference
// R10 - Completion output, then wait next trigger
// R11 - Trigger input dedicated while move enabled
// R12 - Zero-speed trigger alarms until trigger drops
// R13 - Trigger accepted only at non-zero speed
// R14 - Enable resets to 0; inhibit input overrides
// R15 - Preset displacement, default 10000, exact end
// R16 - Keep direction, ramp to preset speed
// R17 - Preset ramp time 0 to 1000 ms
// R18 - Cancel enable requires cancel release to rearm
// R19 - Synchronise inputs, detect edges on samples
// R20 - Final edge halts, latches origin, reports done
module homing_interrupt_positioner #(
   parameter int TICK_CYCLES = homing_pkg::RAMP_TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire homing_pkg::pins_t pins_in,
   input wire logic [31:0] feedback_position,
   input wire logic motor_moving,
   input wire logic motor_dir_fwd,
   output homing_pkg::drive_cmd_t drive_cmd,
   output logic homing_done_out,
   output logic move_done_out,
   output logic alarm_out
);
   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'b00};
      return w == homing_pkg::OFS_CTRL || w == homing_pkg::OFS_DISP ||
             w == homing_pkg::OFS_SPEED || w == homing_pkg::OFS_RAMP ||
             w == homing_pkg::OFS_STAT || w == homing_pkg::OFS_ORIGIN;
   endfunction

   homing_pkg::pins_t s1_reg, s2_reg, s3_reg, rise, fall;
   homing_pkg::hom_state_t hom_reg;
   homing_pkg::move_state_t mv_reg;
   homing_pkg::drive_cmd_t cmd_next;
   logic [31:0] ctrl_reg, disp_reg, origin_reg, aw_addr_word, wr_word;
   logic [31:0] start_pos_reg, accel_dist_reg, travelled, remaining;
   logic [15:0] speed_reg, mv_speed_reg, step_reg, div_q_reg;
   logic [16:0] div_rem_reg, trial;
   logic [10:0] ramp_reg;
   logic [4:0] div_cnt_reg;
   logic [31:0] tick_cnt_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic aw_have_reg, w_have_reg, wr_go, start_reg, tick;
   logic hom_done_reg, mv_done_reg, alarm_reg, armed_reg, mv_dir_reg, hom_dir;
   logic [3:0] method;
   logic method_ok, sw_lvl, sw_rise, sw_fall, out_fwd, slow_fwd, stop_evt;
   logic mv_en, trig_go, mv_end;

   // Two-stage synchroniser, third stage only for edge detection
   // R19 sync and edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   assign rise = s2_reg & ~s3_reg;
   assign fall = ~s2_reg & s3_reg;

   // Write channel: address and data taken in either order
   assign wr_go = aw_have_reg && w_have_reg && !bvalid;
   assign aw_addr_word = {24'h000000, aw_addr_reg[7:2], 2'b00};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= homing_pkg::RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_addr_reg <= awaddr;
            awready <= 1'b0;
            aw_have_reg <= 1'b1;
         end
         if (wvalid && wready) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
            wready <= 1'b0;
            w_have_reg <= 1'b1;
         end
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= mapped(aw_addr_reg) ? homing_pkg::RESP_OKAY : homing_pkg::RESP_SLVERR;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= homing_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= mapped(araddr) ? homing_pkg::RESP_OKAY : homing_pkg::RESP_SLVERR;
         case ({araddr[7:2], 2'b00})
            homing_pkg::OFS_CTRL: rdata <= ctrl_reg;
            homing_pkg::OFS_DISP: rdata <= disp_reg;
            homing_pkg::OFS_SPEED: rdata <= {16'h0000, speed_reg};
            homing_pkg::OFS_RAMP: rdata <= {21'h000000, ramp_reg};
            homing_pkg::OFS_STAT: begin
               rdata <= 32'h0000_0000;
               rdata[homing_pkg::STAT_HOM_BUSY] <= hom_reg != homing_pkg::H_IDLE;
               rdata[homing_pkg::STAT_HOM_DONE] <= hom_done_reg;
               rdata[homing_pkg::STAT_MV_BUSY] <= mv_reg != homing_pkg::M_IDLE;
               rdata[homing_pkg::STAT_MV_DONE] <= mv_done_reg;
               rdata[homing_pkg::STAT_ALARM] <= alarm_reg;
               rdata[homing_pkg::STAT_ARMED] <= armed_reg;
            end
            homing_pkg::OFS_ORIGIN: rdata <= origin_reg;
            default: rdata <= 32'h0000_0000;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Configuration registers; speed and ramp saturate on their low 16/11 bits, displacement on all 32
   // R14 enable resets off
   assign wr_word = merge(32'h0000_0000, wdata_reg, wstrb_reg);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= homing_pkg::CTRL_RESET;
         disp_reg <= homing_pkg::DISP_RESET;
         speed_reg <= homing_pkg::SPEED_RESET;
         ramp_reg <= homing_pkg::RAMP_RESET;
         start_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         if (wr_go) begin
            case (aw_addr_word[7:0])
               homing_pkg::OFS_CTRL: begin
                  ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
                  ctrl_reg[homing_pkg::CTRL_START_BIT] <= 1'b0;
                  start_reg <= wstrb_reg[0] && wdata_reg[homing_pkg::CTRL_START_BIT];
               end
               // R15 displacement range
               homing_pkg::OFS_DISP: begin
                  disp_reg <= (merge(disp_reg, wdata_reg, wstrb_reg) > homing_pkg::DISP_MAX) ?
                              homing_pkg::DISP_MAX : merge(disp_reg, wdata_reg, wstrb_reg);
               end
               // R16 speed range
               homing_pkg::OFS_SPEED: begin
                  speed_reg <= (wr_word[15:0] > homing_pkg::SPEED_MAX) ?
                               homing_pkg::SPEED_MAX : wr_word[15:0];
               end
               // R17 ramp range
               homing_pkg::OFS_RAMP: begin
                  ramp_reg <= (wr_word[10:0] > homing_pkg::RAMP_MAX) ?
                              homing_pkg::RAMP_MAX : wr_word[10:0];
               end
               default: ;
            endcase
         end
      end
   end

   // Homing method decode: 6/8 use positive limit, 7/9 negative
   assign method = ctrl_reg[homing_pkg::CTRL_METHOD_LSB +: 4];
   assign method_ok = method >= homing_pkg::METHOD_FIRST && method <= homing_pkg::METHOD_LAST;
   assign sw_lvl = method[0] ? s2_reg.neg_limit : s2_reg.pos_limit;
   assign sw_rise = method[0] ? rise.neg_limit : rise.pos_limit;
   assign sw_fall = method[0] ? fall.neg_limit : fall.pos_limit;
   assign out_fwd = ~method[0];
   assign slow_fwd = method[3] ? method[0] : ~method[0];
   assign stop_evt = method[3] ? rise.enc_index : sw_rise;

   // R1 R3 R5 R7 low start goes outward fast
   // R2 R4 R6 R8 high start goes back fast
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hom_reg <= homing_pkg::H_IDLE;
         hom_done_reg <= 1'b0;
         hom_dir <= 1'b1;
         origin_reg <= 32'h0000_0000;
      end else begin
         case (hom_reg)
            homing_pkg::H_IDLE: begin
               if (start_reg && method_ok && mv_reg == homing_pkg::M_IDLE) begin
                  hom_done_reg <= 1'b0;
                  hom_reg <= sw_lvl ? homing_pkg::H_FAST_BACK : homing_pkg::H_FAST_OUT;
                  hom_dir <= sw_lvl ? ~out_fwd : out_fwd;
               end
            end
            homing_pkg::H_FAST_OUT: begin
               if (sw_rise) begin
                  hom_reg <= homing_pkg::H_FAST_BACK;
                  hom_dir <= ~out_fwd;
               end
            end
            homing_pkg::H_FAST_BACK: begin
               if (sw_fall) begin
                  hom_reg <= homing_pkg::H_SLOW;
                  hom_dir <= slow_fwd;
               end
            end
            homing_pkg::H_SLOW: begin
               // R20 halt and latch origin
               if (stop_evt) begin
                  hom_reg <= homing_pkg::H_IDLE;
                  hom_done_reg <= 1'b1;
                  origin_reg <= feedback_position;
               end
            end
            default: hom_reg <= homing_pkg::H_IDLE;
         endcase
      end
   end

   // Millisecond tick for the ramp
   assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         tick_cnt_reg <= 32'h0000_0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
   end

   // R11 R14 trigger input gated by enable and inhibit
   assign mv_en = ctrl_reg[homing_pkg::CTRL_ENABLE_BIT] && !s2_reg.inhibit &&
                  ctrl_reg[homing_pkg::CTRL_POS_MODE_BIT];
   assign trig_go = rise.trigger && mv_en && armed_reg && hom_reg == homing_pkg::H_IDLE &&
                    (mv_reg == homing_pkg::M_IDLE || mv_reg == homing_pkg::M_DONE);
   assign travelled = mv_dir_reg ? feedback_position - start_pos_reg :
                                   start_pos_reg - feedback_position;
   assign remaining = disp_reg - travelled;
   assign mv_end = travelled >= disp_reg;
   assign trial = {div_rem_reg[15:0], div_q_reg[15]};

   // R9 R13 trigger takes over at non-zero speed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mv_reg <= homing_pkg::M_IDLE;
         mv_done_reg <= 1'b0;
         alarm_reg <= 1'b0;
         mv_dir_reg <= 1'b1;
         mv_speed_reg <= 16'h0000;
         step_reg <= 16'h0000;
         div_q_reg <= 16'h0000;
         div_rem_reg <= 17'h00000;
         div_cnt_reg <= 5'h00;
         start_pos_reg <= 32'h0000_0000;
         accel_dist_reg <= 32'h0000_0000;
      end else begin
         case (mv_reg)
            homing_pkg::M_IDLE, homing_pkg::M_DONE: begin
               if (trig_go && motor_moving) begin
                  // R16 keep travel direction
                  mv_reg <= homing_pkg::M_DIV;
                  mv_done_reg <= 1'b0;
                  mv_dir_reg <= motor_dir_fwd;
                  start_pos_reg <= feedback_position;
                  mv_speed_reg <= 16'h0000;
                  div_q_reg <= speed_reg;
                  div_rem_reg <= 17'h00000;
                  div_cnt_reg <= homing_pkg::DIV_STEPS;
               end else if (trig_go) begin
                  // R12 zero-speed alarm
                  mv_reg <= homing_pkg::M_ALARM;
                  alarm_reg <= 1'b1;
               end else if (!mv_en) begin
                  mv_reg <= homing_pkg::M_IDLE;
               end
            end
            homing_pkg::M_DIV: begin
               // R17 step per ms is speed over ramp time
               if (ramp_reg == 11'h000) begin
                  step_reg <= speed_reg;
                  mv_reg <= homing_pkg::M_ACCEL;
               end else if (div_cnt_reg == 5'h00) begin
                  step_reg <= (div_q_reg == 16'h0000) ? 16'h0001 : div_q_reg;
                  mv_reg <= homing_pkg::M_ACCEL;
               end else begin
                  div_cnt_reg <= div_cnt_reg - 5'h01;
                  if (trial >= {6'h00, ramp_reg}) begin
                     div_rem_reg <= trial - {6'h00, ramp_reg};
                     div_q_reg <= {div_q_reg[14:0], 1'b1};
                  end else begin
                     div_rem_reg <= trial;
                     div_q_reg <= {div_q_reg[14:0], 1'b0};
                  end
               end
            end
            homing_pkg::M_ACCEL, homing_pkg::M_CRUISE, homing_pkg::M_DECEL: begin
               // R10 R15 exact end raises completion
               if (mv_end) begin
                  mv_reg <= homing_pkg::M_DONE;
                  mv_done_reg <= 1'b1;
                  mv_speed_reg <= 16'h0000;
               end else if (mv_reg != homing_pkg::M_DECEL &&
                            remaining <= (mv_reg == homing_pkg::M_ACCEL ?
                                          travelled : accel_dist_reg)) begin
                  mv_reg <= homing_pkg::M_DECEL;
               end else if (mv_reg == homing_pkg::M_ACCEL && tick) begin
                  if ({1'b0, mv_speed_reg} + {1'b0, step_reg} >= {1'b0, speed_reg}) begin
                     mv_speed_reg <= speed_reg;
                     accel_dist_reg <= travelled;
                     mv_reg <= homing_pkg::M_CRUISE;
                  end else begin
                     mv_speed_reg <= mv_speed_reg + step_reg;
                  end
               end else if (mv_reg == homing_pkg::M_DECEL && tick) begin
                  mv_speed_reg <= (mv_speed_reg > step_reg) ? mv_speed_reg - step_reg : step_reg;
               end
            end
            homing_pkg::M_ALARM: begin
               if (!s2_reg.trigger) begin
                  mv_reg <= homing_pkg::M_IDLE;
                  alarm_reg <= 1'b0;
               end
            end
            default: mv_reg <= homing_pkg::M_IDLE;
         endcase
      end
   end

   // R18 rearm needs cancel release when enabled; release wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_reg <= 1'b1;
      end else if (fall.cancel) begin
         armed_reg <= 1'b1;
      end else if (mv_end && (mv_reg == homing_pkg::M_ACCEL ||
                  mv_reg == homing_pkg::M_CRUISE || mv_reg == homing_pkg::M_DECEL)) begin
         armed_reg <= !ctrl_reg[homing_pkg::CTRL_CANCEL_EN_BIT];
      end
   end

   // Drive command: homing has the motor, else the preset move
   always_comb begin
      cmd_next = '0;
      cmd_next.dir_fwd = hom_dir;
      if (hom_reg != homing_pkg::H_IDLE) begin
         cmd_next.run = 1'b1;
         cmd_next.slow = hom_reg == homing_pkg::H_SLOW;
      end else if (mv_reg != homing_pkg::M_IDLE && mv_reg != homing_pkg::M_ALARM) begin
         cmd_next.run = mv_reg != homing_pkg::M_DONE;
         cmd_next.dir_fwd = mv_dir_reg;
         cmd_next.shield = 1'b1;
         cmd_next.speed = mv_speed_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_cmd <= '0;
         homing_done_out <= 1'b0;
         move_done_out <= 1'b0;
         alarm_out <= 1'b0;
      end else begin
         drive_cmd <= cmd_next;
         homing_done_out <= hom_done_reg;
         move_done_out <= mv_done_reg;
         alarm_out <= alarm_reg;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_hom_reverse;
      (hom_reg == homing_pkg::H_FAST_OUT && sw_rise) |=> ##1
         (drive_cmd.run && !drive_cmd.slow && drive_cmd.dir_fwd == !$past(out_fwd, 2));
   endproperty
   a_hom_reverse: assert property (p_hom_reverse) else $error("no fast reversal"); // R1
   property p_hom_slow;
      (hom_reg == homing_pkg::H_FAST_BACK && sw_fall) |=> ##1
         (drive_cmd.slow && drive_cmd.dir_fwd == $past(slow_fwd, 2));
   endproperty
   a_hom_slow: assert property (p_hom_slow) else $error("no slow phase"); // R5
   property p_hom_high_start;
      (hom_reg == homing_pkg::H_IDLE && start_reg && method_ok && sw_lvl &&
       mv_reg == homing_pkg::M_IDLE) |=> hom_reg == homing_pkg::H_FAST_BACK;
   endproperty
   a_hom_high_start: assert property (p_hom_high_start) else $error("bad high start"); // R2
   property p_hom_stop;
      (hom_reg == homing_pkg::H_SLOW && stop_evt) |=>
         origin_reg == $past(feedback_position) ##1 (!drive_cmd.run && homing_done_out);
   endproperty
   a_hom_stop: assert property (p_hom_stop) else $error("homing stop wrong"); // R20
   property p_alarm_set;
      (trig_go && !motor_moving) |=> ##1 (alarm_out && !drive_cmd.run);
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("zero speed alarm missing"); // R12
   property p_alarm_clear;
      (mv_reg == homing_pkg::M_ALARM && !s2_reg.trigger) |=> ##1 !alarm_out;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared"); // R12
   property p_inhibit;
      (rise.trigger && s2_reg.inhibit &&
       (mv_reg == homing_pkg::M_IDLE || mv_reg == homing_pkg::M_DONE)) |=>
         mv_reg != homing_pkg::M_DIV;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit ignored"); // R14
   property p_done;
      (mv_reg == homing_pkg::M_DECEL && mv_end) |=> mv_reg == homing_pkg::M_DONE ##1
         (move_done_out && !drive_cmd.run && drive_cmd.shield);
   endproperty
   a_done: assert property (p_done) else $error("completion missing"); // R10
   property p_cruise;
      (mv_reg == homing_pkg::M_CRUISE && !mv_end) |-> mv_speed_reg == speed_reg;
   endproperty
   a_cruise: assert property (p_cruise) else $error("cruise speed wrong"); // R16
   property p_rearm;
      (mv_reg inside {homing_pkg::M_ACCEL, homing_pkg::M_CRUISE, homing_pkg::M_DECEL} &&
       mv_end && armed_reg && !fall.cancel &&
       ctrl_reg[homing_pkg::CTRL_CANCEL_EN_BIT]) |=> !armed_reg;
   endproperty
   a_rearm: assert property (p_rearm) else $error("rearm without release"); // R18
endmodule

`default_nettype wire

// file: homing_pkg.sv
// Constants, carrier types and state types of the homing and interrupt-move block
package homing_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DISP = 8'h04;
   localparam logic [7:0] OFS_SPEED = 8'h08;
   localparam logic [7:0] OFS_RAMP = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_ORIGIN = 8'h14;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_METHOD_LSB = 4;
   localparam int CTRL_ENABLE_BIT = 8;
   localparam int CTRL_CANCEL_EN_BIT = 9;
   localparam int CTRL_POS_MODE_BIT = 10;
   localparam int STAT_HOM_BUSY = 0;
   localparam int STAT_HOM_DONE = 1;
   localparam int STAT_MV_BUSY = 2;
   localparam int STAT_MV_DONE = 3;
   localparam int STAT_ALARM = 4;
   localparam int STAT_ARMED = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0600;
   localparam logic [31:0] DISP_RESET = 32'h0000_2710;
   localparam logic [31:0] DISP_MAX = 32'h4000_0000;
   localparam logic [15:0] SPEED_RESET = 16'h07D0;
   localparam logic [15:0] SPEED_MAX = 16'hEA60;
   localparam logic [10:0] RAMP_RESET = 11'h00A;
   localparam logic [10:0] RAMP_MAX = 11'h3E8;
   localparam logic [3:0] METHOD_FIRST = 4'h6;
   localparam logic [3:0] METHOD_LAST = 4'h9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int RAMP_TICK_MS = 1;
   localparam int RAMP_TICK_CYCLES = RAMP_TICK_MS * CLK_FREQ_KHZ;
   localparam logic [4:0] DIV_STEPS = 5'h10;

   typedef struct packed {
      logic pos_limit;
      logic neg_limit;
      logic enc_index;
      logic trigger;
      logic inhibit;
      logic cancel;
   } pins_t;

   typedef struct packed {
      logic run;
      logic dir_fwd;
      logic slow;
      logic shield;
      logic [15:0] speed;
   } drive_cmd_t;

   typedef enum logic [1:0] {H_IDLE, H_FAST_OUT, H_FAST_BACK, H_SLOW} hom_state_t;
   typedef enum logic [2:0] {
      M_IDLE, M_DIV, M_ACCEL, M_CRUISE, M_DECEL, M_DONE, M_ALARM
   } move_state_t;
endpackage

// file: motor_model.sv
// Motor and encoder stand-in that follows the drive command
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   input wire logic aclk,
   input wire homing_pkg::drive_cmd_t drive_cmd,
   input wire logic coast,
   output logic moving,
   output logic dir_fwd,
   output var logic [31:0] position
);
   initial position = 32'h0000_0000;
   assign moving = drive_cmd.run | (drive_cmd.speed != 16'h0000) | coast;
   assign dir_fwd = drive_cmd.run ? drive_cmd.dir_fwd : 1'b1;
   always @(posedge aclk) begin
      if (moving) begin
         position <= dir_fwd ? position + 32'h0000_0001 : position - 32'h0000_0001;
      end
   end
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench for the homing and interrupt-move block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic w; logic [11:0] v; logic [3:0] e;} row_t;
   logic aclk = 1'b0, aresetn = 1'b0, coast = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, pos, d;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, moving, dirf, hdone, mdone, alarm;
   homing_pkg::pins_t pins = '0;
   homing_pkg::drive_cmd_t cmd;
   int n_fail = 0, samples_checked = 0;
   logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
   logic [33:0] re [6] = '{34'h600, 34'h2710, 34'h7D0, 34'hA, 34'h20, 34'h2_0000_0000};
   // Homing steps: CTRL write or pin levels, then {run, dir_fwd, slow, homing done}
   row_t rows [26] = '{
      '{1'b1, 12'h661, 4'hC}, '{1'b0, 12'h20, 4'h8}, '{1'b0, 12'h0, 4'hE},
      '{1'b0, 12'h20, 4'h5}, '{1'b0, 12'h0, 4'h5}, '{1'b0, 12'h10, 4'h5},
      '{1'b1, 12'h671, 4'hC}, '{1'b0, 12'h0, 4'hA}, '{1'b0, 12'h10, 4'h1},
      '{1'b0, 12'h20, 4'h1}, '{1'b1, 12'h681, 4'h8}, '{1'b0, 12'h0, 4'hA},
      '{1'b0, 12'h08, 4'h1}, '{1'b0, 12'h0, 4'h1}, '{1'b1, 12'h691, 4'h8},
      '{1'b0, 12'h10, 4'hC}, '{1'b0, 12'h0, 4'hE}, '{1'b0, 12'h08, 4'h5},
      '{1'b1, 12'h671, 4'h8}, '{1'b0, 12'h10, 4'hC}, '{1'b0, 12'h0, 4'hA},
      '{1'b0, 12'h10, 4'h1}, '{1'b0, 12'h20, 4'h1}, '{1'b1, 12'h661, 4'h8},
      '{1'b0, 12'h0, 4'hE}, '{1'b0, 12'h20, 4'h5}};
   always #12.5 aclk = ~aclk;
   homing_interrupt_positioner #(.TICK_CYCLES(4)) u_homing_interrupt_positioner (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .pins_in(pins), .feedback_position(pos),
      .motor_moving(moving), .motor_dir_fwd(dirf), .drive_cmd(cmd),
      .homing_done_out(hdone), .move_done_out(mdone), .alarm_out(alarm));
   motor_model u_motor_model (.aclk(aclk), .drive_cmd(cmd), .coast(coast),
      .moving(moving), .dir_fwd(dirf), .position(pos));
   task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1));
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic trig(input logic v);
      pins.trigger <= v;
      cyc(6);
   endtask
   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(20000);
      n_fail++;
      complete_run();
   end
   initial begin
      cyc(5);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk("register", {r, d}, re[i]);
      end
      for (int i = 0; i < 26; i++) begin
         if (rows[i].w) wr(8'h00, {20'h00000, rows[i].v});
         else pins <= rows[i].v[5:0];
         cyc(6);
         chk("drive", {cmd.run, cmd.dir_fwd, cmd.slow, hdone}, rows[i].e);
      end
      // Drive command lags the stop by two cycles, so the motor creeps two counts on
      rd(8'h14);
      chk("origin", d, pos - 32'h0000_0002);
      wr(8'h04, 32'h0000_0028);
      wr(8'h0C, 32'h0000_0000);
      wr(8'h00, 32'h0000_0700);
      pins.inhibit <= 1'b1;
      trig(1'b1);
      chk("inhibit", {alarm, cmd.shield}, 2'b00);
      trig(1'b0);
      pins.inhibit <= 1'b0;
      trig(1'b1);
      chk("alarm", alarm, 1'b1);
      trig(1'b0);
      chk("alarm", alarm, 1'b0);
      coast <= 1'b1;
      trig(1'b1);
      chk("shield", cmd.shield, 1'b1);
      coast <= 1'b0;
      while (mdone !== 1'b1) @(posedge aclk);
      chk("done", {mdone, cmd.run, cmd.shield}, 3'b101);
      trig(1'b0);
      coast <= 1'b1;
      trig(1'b1);
      chk("held", mdone, 1'b1);
      trig(1'b0);
      pins.cancel <= 1'b1;
      cyc(4);
      pins.cancel <= 1'b0;
      cyc(4);
      trig(1'b1);
      chk("rearm", mdone, 1'b0);
      coast <= 1'b0;
      aresetn <= 1'b0;
      cyc(5);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("reset", {cmd, mdone, alarm, hdone}, 34'h0);
      rd(8'h00);
      chk("ctrl", {r, d}, 34'h600);
      complete_run();
   end
endmodule
`default_nettype wire
